// File: rtl/pvtid_decode.sv
// Outbound image registers (images 4 to 6) and PCI address decode/translation.
// Assumes an APB master on pclk and a PCI target front end on the same clock.
//
// Decided for this implementation: the APB register port.
`default_nettype none

// Function
// - Enabled image claims address at or above base and below bound
// - Bound of zero means no upper limit above base
// - Image 4 compares on 4 KB units, images 5 and 6 on 64 KB
// - Image 4 VME bits 31..12 are PCI address plus offset
// - Image 5 VME bits 31..16 are PCI address plus offset
// - Image 5 base, bound, offset live in bits 31..16, rest reserved
// - Width field 00/01/10/11 gives 8/16/32/64 bits, resets to 10
// - Space field selects A16, A24, A32, CR/CSR, User1, User2; resets zero
// - Cycle-type bit asks for block transfers, resets zero
// - Cycle-type bit only counts for A24/A32 at 8, 16 or 32 bits
// - A24/A32 at 64 bits may use multiplexed block transfers
// - Posted-write bit posts writes, else coupled, resets zero
// - I/O space image ignores posted bit, always coupled
// - PCI space bit: clear answers memory, set answers I/O
// - Program bit marks cycles program when set, data when clear
// - Supervisor bit marks cycles supervisor when set, else user
// - Enable at bit 31, posted-write at bit 30 of control
// - Image 4 base and bound occupy bits 31..12
module pvtid_decode
    import pvtid_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // PCI request in, VME cycle attributes out
    input  wire pvtid_req_t  pci_req,
    output pvtid_xlat_t      vme_xlat
);

    logic [31:0] ctl_r   [IMG_N];
    logic [31:0] base_r  [IMG_N];
    logic [31:0] bound_r [IMG_N];
    logic [31:0] offs_r  [IMG_N];
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        last_hit_r;
    logic [2:0]  last_img_r;
    pvtid_xlat_t xlat_r;
    pvtid_xlat_t xlat_nxt;
    pvtid_sel_t  sel;
    logic [31:0] lanes;
    logic        wr_en;

    // Window granularity per image
    function automatic logic [31:0] img_gran(input int i);
        return (i == 0) ? GRAN_4K : GRAN_64K;
    endfunction : img_gran

    // Map an APB offset onto a register
    function automatic pvtid_sel_t reg_sel(input logic [11:0] a);
        pvtid_sel_t s;
        s = '{ok: 1'b0, stat: 1'b0, kind: PVTID_K_CTL, img: 2'h0};
        for (int i = 0; i < IMG_N; i++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (a == REG_OFF[i][k])
                begin
                    s.ok   = 1'b1;
                    s.kind = pvtid_kind_t'(k[1:0]);
                    s.img  = i[1:0];
                end
            end
        end
        if (a == OFF_STATUS)
        begin
            s.ok   = 1'b1;
            s.stat = 1'b1;
        end
        return s;
    endfunction : reg_sel

    // Byte-lane merge of a write into the writable bits only
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    // Address modifier from space, cycle kind and privilege
    function automatic logic [5:0] am_code(input pvtid_space_t sp, input logic program_access_flag,
                                           input logic sup, input logic blt,
                                           input logic mblt);
        logic [5:0] base;
        logic [1:0] low;
        base = AM_A16;
        unique case (sp)
            PVTID_A16:   base = AM_A16;
            PVTID_A24:   base = AM_A24;
            PVTID_A32:   base = AM_A32;
            PVTID_CRCSR: base = AM_CRCSR;
            PVTID_USER1: base = AM_USER1;
            PVTID_USER2: base = AM_USER2;
            default:     base = AM_A16;
        endcase
        low = mblt ? AM_MBLT : blt ? AM_BLT : program_access_flag ? AM_PROG : AM_DATA;
        if (sp == PVTID_A16)
            low = AM_DATA; // A16 has no program or block codes
        if (sp == PVTID_CRCSR)
            return AM_CRCSR;
        return base | (6'(sup) << AM_SUP) | {4'h0, low};
    endfunction : am_code

    // APB decode; zero wait states, the read word is staged in setup
    assign sel     = reg_sel(paddr);
    assign lanes   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wr_en   = psel && penable && pwrite && sel.ok && !sel.stat;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && pslverr_r;
    assign prdata  = prdata_r;

    // Register writes; reserved bits stay zero through the masks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < IMG_N; i++)
            begin
                ctl_r[i]   <= CTL_RESET;
                base_r[i]  <= 32'h0000_0000;
                bound_r[i] <= 32'h0000_0000;
                offs_r[i]  <= 32'h0000_0000;
            end
        end
        else
        begin
            for (int i = 0; i < IMG_N; i++)
            begin
                if (wr_en && sel.img == i[1:0])
                begin
                    unique case (sel.kind)
                        PVTID_K_CTL:   ctl_r[i]   <= merge(ctl_r[i], pwdata,
                                                           CTL_MASK & lanes);
                        PVTID_K_BASE:  base_r[i]  <= merge(base_r[i], pwdata,
                                                           img_gran(i) & lanes);
                        PVTID_K_BOUND: bound_r[i] <= merge(bound_r[i], pwdata,
                                                           img_gran(i) & lanes);
                        PVTID_K_OFFS:  offs_r[i]  <= merge(offs_r[i], pwdata,
                                                           img_gran(i) & lanes);
                    endcase
                end
            end
        end
    end

    // Read data and error staged in the setup cycle so they come from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_r <= !sel.ok;
            if (!sel.ok)
                prdata_r <= 32'h0000_0000;
            else if (sel.stat)
                prdata_r <= (32'(last_hit_r) << STAT_HIT_BIT)
                          | (32'(last_img_r) << STAT_IMG_LSB);
            else
            begin
                unique case (sel.kind)
                    PVTID_K_CTL:   prdata_r <= ctl_r[sel.img];
                    PVTID_K_BASE:  prdata_r <= base_r[sel.img];
                    PVTID_K_BOUND: prdata_r <= bound_r[sel.img];
                    PVTID_K_OFFS:  prdata_r <= offs_r[sel.img];
                endcase
            end
        end
    end

    // Window compare and translation; lowest image wins on overlap
    always_comb
    begin
        logic [31:0]  g;
        pvtid_space_t sp;
        pvtid_width_t wd;
        logic         a2432;
        logic         in_win;
        g     = GRAN_4K;
        sp    = PVTID_A16;
        wd    = PVTID_W32;
        a2432 = 1'b0;
        in_win = 1'b0;
        xlat_nxt       = '0;
        xlat_nxt.width = PVTID_W32;
        xlat_nxt.valid = pci_req.valid;
        for (int i = IMG_N - 1; i >= 0; i--)
        begin
            g      = img_gran(i);
            sp     = pvtid_space_t'(ctl_r[i][CTL_SPC_LSB +: 3]);
            wd     = pvtid_width_t'(ctl_r[i][CTL_WID_LSB +: 2]);
            a2432  = (sp == PVTID_A24) || (sp == PVTID_A32);
            in_win = ((pci_req.addr & g) >= (base_r[i] & g))
                  && (((bound_r[i] & g) == 32'h0)
                      || ((pci_req.addr & g) < (bound_r[i] & g)));
            // Reserved spaces never claim: there is no cycle to generate
            if (pci_req.valid && ctl_r[i][CTL_EN_BIT] && in_win
                && (pci_req.io == ctl_r[i][CTL_IOS_BIT])
                && sp != PVTID_RSV3 && sp != PVTID_RSV4)
            begin
                xlat_nxt.hit      = 1'b1;
                xlat_nxt.img      = IMG_FIRST + i[2:0];
                xlat_nxt.vme_addr = ((pci_req.addr & g) + (offs_r[i] & g))
                                  | (pci_req.addr & ~g);
                xlat_nxt.width    = wd;
                xlat_nxt.blt      = ctl_r[i][CTL_BLK_BIT] && a2432
                                  && wd != PVTID_W64;
                xlat_nxt.mblt     = a2432 && wd == PVTID_W64;
                xlat_nxt.posted   = pci_req.write && ctl_r[i][CTL_PW_BIT]
                                  && !ctl_r[i][CTL_IOS_BIT];
                xlat_nxt.am       = am_code(sp, ctl_r[i][CTL_PRG_BIT],
                                            ctl_r[i][CTL_SUPER_BIT], xlat_nxt.blt,
                                            xlat_nxt.mblt);
            end
        end
    end

    // Answer registered one cycle after each request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xlat_r <= '0;
        else
            xlat_r <= xlat_nxt;
    end

    assign vme_xlat = xlat_r;

    // Hit and image of the last request, claimed or not, shown to software in the status word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_hit_r <= 1'b0;
            last_img_r <= 3'h0;
        end
        else if (xlat_nxt.valid)
        begin
            last_hit_r <= xlat_nxt.hit;
            last_img_r <= xlat_nxt.img;
        end
    end

    // Assertion helpers: request and image 4/5 settings seen one cycle back
    pvtid_req_t  req_q;
    logic [31:0] ctl4_q;
    logic [31:0] base4_q;
    logic [31:0] bound4_q;
    logic [31:0] offs4_q;
    logic [31:0] offs5_q;
    logic [31:0] ctl5_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_q    <= '0;
            ctl4_q   <= 32'h0;
            base4_q  <= 32'h0;
            bound4_q <= 32'h0;
            offs4_q  <= 32'h0;
            offs5_q  <= 32'h0;
            ctl5_q   <= 32'h0;
        end
        else
        begin
            req_q    <= pci_req;
            ctl4_q   <= ctl_r[0];
            base4_q  <= base_r[0];
            bound4_q <= bound_r[0];
            offs4_q  <= offs_r[0];
            offs5_q  <= offs_r[1];
            ctl5_q   <= ctl_r[1];
        end
    end

    // All checks run on pclk and sleep in reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Full-word write to image 5 control
    sequence s_ctl5_write;
        psel && penable && pwrite && paddr == REG_OFF[1][0] && pstrb == 4'hF;
    endsequence

    // Image 4 claims only inside its window
    a_hit_in_window: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST && bound4_q != 32'h0 |->
        req_q.addr[31:12] >= base4_q[31:12] && req_q.addr[31:12] < bound4_q[31:12])
        else $error("image 4 claimed outside its window");

    // Zero bound leaves the window open above base
    a_zero_bound_open: assert property (
        pci_req.valid && ctl_r[0][CTL_EN_BIT] && !pci_req.io && !ctl_r[0][CTL_IOS_BIT]
        && ctl_r[0][CTL_SPC_LSB +: 3] == 3'h2 && bound_r[0] == 32'h0
        && pci_req.addr[31:12] >= base_r[0][31:12] |=> vme_xlat.hit)
        else $error("open-ended image 4 failed to claim");

    // Offsets add on the image's granularity
    a_offset_img4: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST |->
        vme_xlat.vme_addr[31:12] == 20'(req_q.addr[31:12] + offs4_q[31:12])
        && vme_xlat.vme_addr[11:0] == req_q.addr[11:0])
        else $error("image 4 translation wrong");

    a_offset_img5: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST + 3'h1 |->
        vme_xlat.vme_addr[31:16] == 16'(req_q.addr[31:16] + offs5_q[31:16])
        && vme_xlat.vme_addr[15:0] == req_q.addr[15:0])
        else $error("image 5 translation wrong");

    // Image 4 answers only the PCI space its bit selects
    a_space_match: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST |-> req_q.io == ctl4_q[CTL_IOS_BIT])
        else $error("image 4 claimed in the wrong PCI space");

    // Posting only for memory-space writes
    a_io_coupled: assert property (
        vme_xlat.hit && req_q.io |-> !vme_xlat.posted)
        else $error("I/O image posted a write");

    a_posted_follow: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST && req_q.write && !req_q.io |->
        vme_xlat.posted == ctl4_q[CTL_PW_BIT])
        else $error("posted flag does not follow control");

    // Block codes only where the width allows
    a_blt_gated: assert property (
        vme_xlat.blt |-> vme_xlat.width != PVTID_W64 && !vme_xlat.mblt
        && (vme_xlat.am[5:3] == 3'h7 || vme_xlat.am[5:3] == 3'h1))
        else $error("block transfer outside A24/A32 narrow widths");

    a_mblt_wide: assert property (
        vme_xlat.mblt |-> vme_xlat.width == PVTID_W64 && vme_xlat.am[1:0] == AM_MBLT)
        else $error("multiplexed block code wrong");

    // Privilege bit copied into the modifier
    a_am_privilege: assert property (
        vme_xlat.hit && vme_xlat.img == IMG_FIRST && vme_xlat.am != AM_CRCSR |->
        vme_xlat.am[AM_SUP] == ctl4_q[CTL_SUPER_BIT])
        else $error("supervisor code bit wrong");

    // One answer per request, one cycle later
    a_answer_next: assert property (
        pci_req.valid |=> vme_xlat.valid ##0 $past(pci_req.valid, 1))
        else $error("request not answered next cycle");

    // Stored control word is the masked write
    a_ctl5_written: assert property (
        s_ctl5_write |=> ctl_r[1] == ($past(pwdata) & CTL_MASK) ##1 ctl5_q == ctl_r[1])
        else $error("image 5 control write not stored");

endmodule : pvtid_decode

`default_nettype wire

// File: rtl/pvtid_pkg.sv
// Shared constants and types for the PCI-to-VME outbound image decoder.
// Assumes a single 250 MHz APB clock and same-clock PCI request logic.
`default_nettype none

package pvtid_pkg;

    // Images held here: index 0, 1, 2 are images 4, 5, 6
    localparam int          IMG_N     = 3;
    localparam logic [2:0]  IMG_FIRST = 3'h4;

    // Register offsets, one row per image: control, base, bound, offset
    localparam logic [11:0] REG_OFF [IMG_N][4] = '{
        '{12'h1A0, 12'h1A4, 12'h1A8, 12'h1B0},
        '{12'h1B4, 12'h1B8, 12'h1BC, 12'h1C0},
        '{12'h1C8, 12'h1CC, 12'h1D0, 12'h1D4}
    };
    localparam logic [11:0] OFF_STATUS = 12'h1FC;

    // Control register field positions
    localparam int CTL_EN_BIT    = 31;
    localparam int CTL_PW_BIT    = 30;
    localparam int CTL_WID_LSB   = 22;
    localparam int CTL_SPC_LSB   = 16;
    localparam int CTL_PRG_BIT   = 14;
    localparam int CTL_SUPER_BIT = 12;
    localparam int CTL_BLK_BIT   = 8;
    localparam int CTL_IOS_BIT   = 0;
    localparam logic [31:0] CTL_MASK  = 32'hC0C7_5101;
    localparam logic [31:0] CTL_RESET = 32'h0080_0000;

    // Window granularity masks
    localparam logic [31:0] GRAN_4K  = 32'hFFFF_F000;
    localparam logic [31:0] GRAN_64K = 32'hFFFF_0000;

    // Status register fields
    localparam int STAT_HIT_BIT = 0;
    localparam int STAT_IMG_LSB = 4;

    // Address modifier building blocks
    localparam logic [5:0] AM_A16    = 6'h28;
    localparam logic [5:0] AM_A24    = 6'h38;
    localparam logic [5:0] AM_A32    = 6'h08;
    localparam logic [5:0] AM_CRCSR  = 6'h2F;
    localparam logic [5:0] AM_USER1  = 6'h10;
    localparam logic [5:0] AM_USER2  = 6'h18;
    localparam int         AM_SUP    = 2;
    localparam logic [1:0] AM_MBLT   = 2'h0;
    localparam logic [1:0] AM_DATA   = 2'h1;
    localparam logic [1:0] AM_PROG   = 2'h2;
    localparam logic [1:0] AM_BLT    = 2'h3;

    typedef enum logic [1:0] {PVTID_W8, PVTID_W16, PVTID_W32, PVTID_W64} pvtid_width_t;
    typedef enum logic [2:0] {PVTID_A16, PVTID_A24, PVTID_A32, PVTID_RSV3, PVTID_RSV4,
                              PVTID_CRCSR, PVTID_USER1, PVTID_USER2} pvtid_space_t;
    typedef enum logic [1:0] {PVTID_K_CTL, PVTID_K_BASE, PVTID_K_BOUND,
                              PVTID_K_OFFS} pvtid_kind_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        io;
        logic        write;
    } pvtid_req_t;

    typedef struct packed {
        logic         valid;
        logic         hit;
        logic [2:0]   img;
        logic [31:0]  vme_addr;
        logic [5:0]   am;
        pvtid_width_t width;
        logic         blt;
        logic         mblt;
        logic         posted;
    } pvtid_xlat_t;

    typedef struct packed {
        logic        ok;
        logic        stat;
        pvtid_kind_t kind;
        logic [1:0]  img;
    } pvtid_sel_t;

endpackage : pvtid_pkg

`default_nettype wire

// File: testbench/pvtid_pci_partner.sv
// PCI master partner: issues queued decode requests and collects the answers.
// Assumes the decoder answers one cycle after each request, on the same pclk.
`default_nettype none

module pvtid_pci_partner
    import pvtid_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Decoder side
    output var  pvtid_req_t  pci_req,
    input  wire pvtid_xlat_t vme_xlat
);
    timeunit 1ns;
    timeprecision 1ps;

    pvtid_req_t  req_q [$];
    pvtid_xlat_t res_q [$];

    // One request per edge while queued; idle lines toggle so stale values never match
    initial
    begin
        pci_req = '0;
        forever
        begin
            @(posedge pclk);
            if (vme_xlat.valid === 1'b1 && presetn === 1'b1)
                res_q.push_back(vme_xlat);
            if (req_q.size() != 0)
                pci_req <= req_q.pop_front();
            else
                pci_req <= '{valid: 1'b0, addr: ~pci_req.addr, io: ~pci_req.io,
                             write: ~pci_req.write};
        end
    end
endmodule : pvtid_pci_partner

`default_nettype wire

// File: testbench/tb_pvtid_decode.sv
// Self-checking bench for the outbound image decoder against a behavioural model.
// Assumes the package and the PCI partner model are compiled before this file.
`default_nettype none

module tb_pvtid_decode
    import pvtid_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    pvtid_req_t  pci_req;
    pvtid_xlat_t vme_xlat, exp_q [$];
    logic [31:0] mreg [3][4];
    logic        st_hit;
    logic [2:0]  st_img;
    int          fails, checks;

    pvtid_decode i_pvtid_decode (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pci_req(pci_req),
        .vme_xlat(vme_xlat));
    pvtid_pci_partner i_pvtid_pci_partner (.pclk(pclk), .presetn(presetn),
        .pci_req(pci_req), .vme_xlat(vme_xlat));

    // 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // Register index from byte address: 12 is status, -1 unmapped
    function automatic int find(input logic [11:0] a);
        find = (a == OFF_STATUS) ? 12 : -1;
        for (int i = 0; i < IMG_N; i++)
            for (int k = 0; k < 4; k++)
                if (REG_OFF[i][k] == a)
                    find = i * 4 + k;
    endfunction : find

    // Expected answer; lower index wins where windows overlap
    function automatic pvtid_xlat_t model(input pvtid_req_t r);
        pvtid_xlat_t x;
        logic [31:0] c, m;
        logic [2:0]  sp;
        logic [1:0]  lo;
        logic        ab;
        x = '0;
        x.valid = 1'b1;
        x.width = PVTID_W32;
        for (int i = 2; i >= 0; i--)
        begin
            c = mreg[i][0];
            m = (i == 0) ? GRAN_4K : GRAN_64K;
            sp = c[18:16];
            ab = (sp == PVTID_A24) || (sp == PVTID_A32);
            if (c[31] && r.io == c[0] && sp != PVTID_RSV3 && sp != PVTID_RSV4
                && (r.addr & m) >= (mreg[i][1] & m)
                && ((mreg[i][2] & m) == '0 || (r.addr & m) < (mreg[i][2] & m)))
            begin
                x.hit = 1'b1;
                x.img = 3'(4 + i);
                x.vme_addr = ((r.addr & m) + (mreg[i][3] & m)) | (r.addr & ~m);
                x.width = pvtid_width_t'(c[23:22]);
                x.mblt = ab && c[23:22] == 2'h3;
                x.blt = ab && c[23:22] != 2'h3 && c[8];
                x.posted = r.write & c[30] & ~c[0];
                lo = x.mblt ? AM_MBLT : x.blt ? AM_BLT : c[14] ? AM_PROG : AM_DATA;
                case (sp)
                    PVTID_A16:   x.am = c[12] ? 6'h2D : 6'h29;
                    PVTID_CRCSR: x.am = AM_CRCSR;
                    PVTID_A24:   x.am = AM_A24 | 6'(lo) | (6'(c[12]) << AM_SUP);
                    PVTID_A32:   x.am = AM_A32 | 6'(lo) | (6'(c[12]) << AM_SUP);
                    PVTID_USER1: x.am = AM_USER1 | 6'(lo) | (6'(c[12]) << AM_SUP);
                    default:     x.am = AM_USER2 | 6'(lo) | (6'(c[12]) << AM_SUP);
                endcase
            end
        end
        return x;
    endfunction : model

    // APB transfer: setup, then access held until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] rv, lm, m;
        logic        e;
        int          x;
        x = find(a);
        apb(1'b1, a, d, s, rv, e);
        check("write error", e, x < 0);
        lm = '0;
        for (int b = 0; b < 4; b++)
            if (s[b])
                lm[8*b+:8] = 8'hFF;
        m = (x % 4 == 0) ? CTL_MASK : (x < 4 ? GRAN_4K : GRAN_64K);
        if (x >= 0 && x < 12)
            mreg[x/4][x%4] = (mreg[x/4][x%4] & ~lm) | (d & lm & m);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        logic [31:0] rv, ex;
        logic        e;
        int          x;
        x = find(a);
        apb(1'b0, a, 32'h0000_0000, 4'h0, rv, e);
        ex = (x < 0) ? '0 : (x == 12) ? {25'h0, st_img, 3'h0, st_hit} : mreg[x/4][x%4];
        check("read data", rv, ex);
        check("read error", e, x < 0);
    endtask : rd

    task automatic pci(input logic [31:0] a, input logic io, input logic w);
        pvtid_req_t r;
        r = '{valid: 1'b1, addr: a, io: io, write: w};
        i_pvtid_pci_partner.req_q.push_back(r);
        exp_q.push_back(model(r));
        st_hit = exp_q[$].hit;
        st_img = exp_q[$].img;
    endtask : pci

    task automatic drain();
        int n;
        n = 0;
        while (i_pvtid_pci_partner.res_q.size() < exp_q.size() && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        check("answer count", i_pvtid_pci_partner.res_q.size(), exp_q.size());
        while (exp_q.size() != 0 && i_pvtid_pci_partner.res_q.size() != 0)
            check("vme_xlat", i_pvtid_pci_partner.res_q.pop_front(), exp_q.pop_front());
    endtask : drain

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check("xlat in reset", vme_xlat, '0);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 4; k++)
                mreg[i][k] = (k == 0) ? CTL_RESET : '0;
        {st_hit, st_img} = '0;
        exp_q.delete();
        i_pvtid_pci_partner.res_q.delete();
    endtask : do_reset

    task automatic read_all();
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 4; k++)
                rd(REG_OFF[i][k]);
        rd(OFF_STATUS);
    endtask : read_all

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        void'($urandom(66412));
        do_reset();
        read_all();
        $display("test reset values done");
        // Field masks, byte lanes, read-only status, unmapped places
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 4; k++)
                wr(REG_OFF[i][k], 32'hFFFF_FFFF, 4'hF);
        read_all();
        repeat (24)
        begin
            wr(REG_OFF[$urandom() % 3][$urandom() % 4], $urandom(), 4'($urandom()));
            rd(REG_OFF[$urandom() % 3][$urandom() % 4]);
        end
        wr(OFF_STATUS, 32'hFFFF_FFFF, 4'hF);
        wr(12'h1AC, 32'hFFFF_FFFF, 4'hF);
        wr(12'h000, 32'h1234_5678, 4'hF);
        read_all();
        rd(12'h1AC);
        rd(12'h1C4);
        $display("test register access done");
        // Image 5 window edges, then bound zero
        for (int i = 0; i < 3; i++)
            wr(REG_OFF[i][0], 32'h0000_0000, 4'hF);
        wr(REG_OFF[1][0], 32'h8082_0000, 4'hF);
        wr(REG_OFF[1][1], 32'h0012_0000, 4'hF);
        wr(REG_OFF[1][2], 32'h0015_0000, 4'hF);
        wr(REG_OFF[1][3], 32'hFFF0_0000, 4'hF);
        pci(32'h0011_FFFF, 1'b0, 1'b0);
        pci(32'h0012_0000, 1'b0, 1'b1);
        pci(32'h0014_FFFF, 1'b0, 1'b0);
        pci(32'h0015_0000, 1'b0, 1'b0);
        pci(32'h0012_ABCD, 1'b1, 1'b0);
        drain();
        wr(REG_OFF[1][2], 32'h0000_0000, 4'hF);
        pci(32'hFFFF_FFFF, 1'b0, 1'b0);
        pci(32'h0011_FFFF, 1'b0, 1'b0);
        drain();
        $display("test window edges done");
        // Image 4 at 4 KB with overlap over images 5 and 6
        wr(REG_OFF[1][2], 32'h0015_0000, 4'hF);
        wr(REG_OFF[0][0], 32'h8082_0000, 4'hF);
        wr(REG_OFF[0][1], 32'h0012_3000, 4'hF);
        wr(REG_OFF[0][2], 32'h0012_5000, 4'hF);
        wr(REG_OFF[0][3], 32'h8000_1000, 4'hF);
        wr(REG_OFF[2][0], 32'h80C1_0000, 4'hF);
        for (int k = 0; k < 4; k++)
            pci(32'h0012_2FFF + 32'(k) * 32'h0000_1001, 1'b0, 1'b1);
        pci(32'h0012_5000, 1'b0, 1'b0);
        pci(32'h0099_0010, 1'b0, 1'b0);
        drain();
        wr(REG_OFF[0][2], 32'h0000_0000, 4'hF);
        pci(32'h0F12_3456, 1'b0, 1'b0);
        drain();
        rd(OFF_STATUS);
        $display("test image priority done");
        // Every space, width and PCI space code, random attribute bits
        wr(REG_OFF[0][0], 32'h0000_0000, 4'hF);
        wr(REG_OFF[2][0], 32'h0000_0000, 4'hF);
        wr(REG_OFF[1][1], 32'h0040_0000, 4'hF);
        wr(REG_OFF[1][2], 32'h0080_0000, 4'hF);
        for (int j = 0; j < 64; j++)
        begin
            wr(REG_OFF[1][0], 32'h8000_0000 | (32'(j[4:3]) << CTL_WID_LSB)
               | (32'(j[2:0]) << CTL_SPC_LSB) | 32'(j[5]) | ($urandom() & 32'h4000_5100), 4'hF);
            repeat (2)
                pci(32'h0040_0000 + $urandom() % 32'h0050_0000, 1'($urandom()),
                    1'($urandom()));
            drain();
        end
        $display("test modes done");
        // Reset in mid-run
        pci(32'h0041_0000, 1'b0, 1'b0);
        @(posedge pclk);
        do_reset();
        read_all();
        $display("test second reset done");
        conclude();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        fails++;
        $display("unexpected run length: expected end seen timeout");
        conclude();
    end
endmodule : tb_pvtid_decode

`default_nettype wire
